// ===== core/nibble_xor_pkg.sv
// Package: opcodes, field widths and reset values for the swap/xor datapath
package nibble_xor_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic DEST_W = 1'b0;
    localparam logic DEST_F = 1'b1;

    // Operation select
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_NIBBLE_SWAP = 2'b01,
        OP_REG_XOR = 2'b10,
        OP_LITERAL_XOR = 2'b11
    } op_t;

    // Issued instruction
    typedef struct packed {
        logic valid;
        op_t op;
        logic dest;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] literal;
    } instr_t;

    // Execution state: idle or read
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01
    } state_t;

    // Whole datapath state
    typedef struct packed {
        state_t state;
        instr_t instr;
        logic [DATA_W-1:0] w;
        logic zero;
        logic done;
        logic [DATA_W-1:0] result;
    } core_t;
endpackage

// ===== core/file_ram.sv
// File register memory with registered read data
`timescale 1ns/1ns
module file_ram #(
    parameter int DEPTH = 128,
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Read port
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata
);
    // Cleared at load so a read before the first write is defined
    logic [DW-1:0] mem [DEPTH] = '{default: '0};
    logic [DW-1:0] rdata_q;

    // Storage and registered read
    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (!i_rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[i_raddr];
        end
    end

    assign o_rdata = rdata_q;
endmodule

// ===== core/nibble_swap_xor_ops.sv
// Execution datapath for nibble swap, register xor and literal xor
// Operation
// - Swap moves file bits 3..0 to result 7..4, 7..4 to 3..0; flags unchanged
// - Swap destination 0 writes working register, 1 writes file register
// - Register xor: working xor file at 7-bit address; destination picks target
// - Register xor updates zero flag only
// - Literal xor with 8-bit immediate, always to working register, zero flag only
`timescale 1ns/1ns
module nibble_swap_xor_ops #(
    parameter int DEPTH = nibble_xor_pkg::FILE_DEPTH
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Instruction issue
    input wire nibble_xor_pkg::instr_t i_instr,
    output logic o_ready,
    // Results
    output logic o_done,
    output logic [nibble_xor_pkg::DATA_W-1:0] o_result,
    output logic [nibble_xor_pkg::DATA_W-1:0] o_w,
    output logic o_zero
);
    localparam int DW = nibble_xor_pkg::DATA_W;
    localparam int AW = nibble_xor_pkg::ADDR_W;
    localparam int NIB = DW / 2;

    nibble_xor_pkg::core_t s_q;
    nibble_xor_pkg::core_t s_d;
    logic [DW-1:0] rdata;
    logic we;
    logic [DW-1:0] wdata;

    // Nibble exchange of a byte
    function automatic logic [DW-1:0] swap_nib(input logic [DW-1:0] v);
        swap_nib = {v[NIB-1:0], v[DW-1:NIB]};
    endfunction

    // Zero test of a byte
    function automatic logic is_zero(input logic [DW-1:0] v);
        is_zero = (v == nibble_xor_pkg::ZERO_BYTE);
    endfunction

    file_ram #(
        .DEPTH(DEPTH),
        .AW(AW),
        .DW(DW)
    ) u_ram (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_raddr(i_instr.addr),
        .o_rdata(rdata),
        .i_we(we),
        .i_waddr(s_q.instr.addr),
        .i_wdata(wdata)
    );

    // Next state and write-back
    always_comb begin
        logic [DW-1:0] res;
        res = '0;
        s_d = s_q;
        s_d.done = 1'b0;
        we = 1'b0;
        wdata = '0;
        case (s_q.state)
            nibble_xor_pkg::ST_IDLE: begin
                if (i_instr.valid) begin
                    if (i_instr.op == nibble_xor_pkg::OP_LITERAL_XOR) begin
                        res = s_q.w ^ i_instr.literal;
                        s_d.w = res;
                        s_d.zero = is_zero(res);
                        s_d.result = res;
                        s_d.done = 1'b1;
                    end else if (i_instr.op != nibble_xor_pkg::OP_NONE) begin
                        s_d.instr = i_instr;
                        s_d.state = nibble_xor_pkg::ST_READ;
                    end
                end
            end
            nibble_xor_pkg::ST_READ: begin
                if (s_q.instr.op == nibble_xor_pkg::OP_NIBBLE_SWAP) begin
                    res = swap_nib(rdata);
                end else begin
                    res = s_q.w ^ rdata;
                    s_d.zero = is_zero(res);
                end
                if (s_q.instr.dest == nibble_xor_pkg::DEST_F) begin
                    we = 1'b1;
                    wdata = res;
                end else begin
                    s_d.w = res;
                end
                s_d.result = res;
                s_d.done = 1'b1;
                s_d.state = nibble_xor_pkg::ST_IDLE;
            end
            default: begin
                s_d.state = nibble_xor_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.w <= nibble_xor_pkg::W_RESET;
            s_q.state <= nibble_xor_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign o_ready = (s_q.state == nibble_xor_pkg::ST_IDLE);
    assign o_done = s_q.done;
    assign o_result = s_q.result;
    assign o_w = s_q.w;
    assign o_zero = s_q.zero;

    // Checks
    property p_swap_flags;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_READ
            && s_q.instr.op == nibble_xor_pkg::OP_NIBBLE_SWAP) |=> $stable(o_zero);
    endproperty
    a_swap_flags: assert property (p_swap_flags) else $error("swap changed zero");

    property p_swap_val;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_READ
            && s_q.instr.op == nibble_xor_pkg::OP_NIBBLE_SWAP)
            |=> o_result == {$past(rdata[NIB-1:0]), $past(rdata[DW-1:NIB])};
    endproperty
    a_swap_val: assert property (p_swap_val) else $error("swap result wrong");

    property p_dest_w;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_READ && s_q.instr.dest == nibble_xor_pkg::DEST_W)
            |-> !we ##1 (o_w == o_result);
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("dest 0 not to w");

    property p_dest_f;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_READ && s_q.instr.dest == nibble_xor_pkg::DEST_F)
            |-> we ##1 $stable(o_w);
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("dest 1 not to file");

    property p_reg_xor;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_READ
            && s_q.instr.op == nibble_xor_pkg::OP_REG_XOR)
            |=> o_result == ($past(rdata) ^ $past(s_q.w));
    endproperty
    a_reg_xor: assert property (p_reg_xor) else $error("reg xor wrong");

    property p_reg_zero;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_READ
            && s_q.instr.op == nibble_xor_pkg::OP_REG_XOR)
            |=> o_done && (o_zero == (o_result == nibble_xor_pkg::ZERO_BYTE));
    endproperty
    a_reg_zero: assert property (p_reg_zero) else $error("reg xor zero wrong");

    property p_lit;
        @(posedge i_clock) disable iff (!i_rst_n)
        (o_ready && i_instr.valid && i_instr.op == nibble_xor_pkg::OP_LITERAL_XOR)
            |=> o_done && o_w == ($past(s_q.w) ^ $past(i_instr.literal)) && o_ready;
    endproperty
    a_lit: assert property (p_lit) else $error("literal xor wrong");

    property p_zero_def;
        @(posedge i_clock) disable iff (!i_rst_n)
        $changed(o_zero) |-> o_done && o_zero == (o_result == nibble_xor_pkg::ZERO_BYTE);
    endproperty
    a_zero_def: assert property (p_zero_def) else $error("zero flag mismatch");

    // File operation taken, one busy cycle, then the answer
    sequence s_take_file;
        o_ready && i_instr.valid
            && (i_instr.op == nibble_xor_pkg::OP_NIBBLE_SWAP
            || i_instr.op == nibble_xor_pkg::OP_REG_XOR);
    endsequence

    sequence s_busy_then_done;
        (!o_ready && !o_done) ##1 (o_ready && o_done);
    endsequence

    property p_file_timing;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take_file |=> s_busy_then_done;
    endproperty
    a_file_timing: assert property (p_file_timing) else $error("file op timing");

    property p_lit_zero;
        @(posedge i_clock) disable iff (!i_rst_n)
        (o_ready && i_instr.valid && i_instr.op == nibble_xor_pkg::OP_LITERAL_XOR)
            |=> o_zero == (o_w == nibble_xor_pkg::ZERO_BYTE);
    endproperty
    a_lit_zero: assert property (p_lit_zero) else $error("literal zero wrong");

    property p_idle_no_write;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_IDLE) |-> !we;
    endproperty
    a_idle_no_write: assert property (p_idle_no_write) else $error("idle file write");

    property p_xor_wdata;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_READ
            && s_q.instr.op == nibble_xor_pkg::OP_REG_XOR
            && s_q.instr.dest == nibble_xor_pkg::DEST_F)
            |-> we && wdata == (rdata ^ s_q.w);
    endproperty
    a_xor_wdata: assert property (p_xor_wdata) else $error("xor file data wrong");

    property p_swap_wdata;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_q.state == nibble_xor_pkg::ST_READ
            && s_q.instr.op == nibble_xor_pkg::OP_NIBBLE_SWAP
            && s_q.instr.dest == nibble_xor_pkg::DEST_F)
            |-> we && wdata == {rdata[NIB-1:0], rdata[DW-1:NIB]};
    endproperty
    a_swap_wdata: assert property (p_swap_wdata) else $error("swap file data wrong");
endmodule

// ===== sim/tb.sv
// Self-checking bench for the nibble swap and xor datapath
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic learn;
        logic [6:0] addr;
        logic [7:0] res;
        logic [7:0] w;
        logic z;
    } note_t;
    localparam nibble_xor_pkg::op_t NOP = nibble_xor_pkg::OP_NONE;
    localparam nibble_xor_pkg::op_t SWP = nibble_xor_pkg::OP_NIBBLE_SWAP;
    localparam nibble_xor_pkg::op_t RX = nibble_xor_pkg::OP_REG_XOR;
    localparam nibble_xor_pkg::op_t LX = nibble_xor_pkg::OP_LITERAL_XOR;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    nibble_xor_pkg::instr_t i_instr = '0;
    logic o_ready, o_done, o_zero;
    logic [7:0] o_result, o_w;
    note_t q[$];
    note_t nt;
    logic [7:0] mem_m [128];
    logic [7:0] w_m = 8'h00;
    logic z_m = 1'b0;
    logic [6:0] a;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed;

    nibble_swap_xor_ops u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_instr(i_instr),
        .o_ready(o_ready), .o_done(o_done), .o_result(o_result), .o_w(o_w), .o_zero(o_zero));

    // Clock, 20 ns period
    initial begin
        forever #10 i_clock = ~i_clock;
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits for ready, notes the expected outcome, presents the instruction
    task automatic issue(input nibble_xor_pkg::op_t op, input logic d, input logic [6:0] ad,
        input logic [7:0] k, input logic lrn);
        logic [7:0] r;
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 10) begin
            @(negedge i_clock);
            n++;
        end
        r = (op == SWP) ? {mem_m[ad][3:0], mem_m[ad][7:4]} :
            (op == RX) ? (w_m ^ mem_m[ad]) : (w_m ^ k);
        if (op == RX || op == LX) z_m = (r == 8'h00);
        if (op == LX || (op != NOP && d == nibble_xor_pkg::DEST_W)) w_m = r;
        else if (op != NOP) mem_m[ad] = r;
        if (op != NOP) q.push_back({lrn, ad, r, w_m, z_m});
        i_instr = {1'b1, op, d, ad, k};
        @(negedge i_clock);
    endtask

    // First touch of an address: swap into W to learn its power-up content
    task automatic learn(input logic [6:0] ad);
        issue(SWP, nibble_xor_pkg::DEST_W, ad, 8'h00, 1'b1);
        i_instr.valid = 1'b0;
        repeat (2) @(negedge i_clock);
    endtask

    // Result watcher
    always @(negedge i_clock) begin
        if (o_done === 1'b1) begin
            if (q.size() == 0) begin
                check("spurious done", 8'h01, 8'h00);
            end else begin
                nt = q.pop_front();
                if (nt.learn) begin
                    w_m = o_result;
                    mem_m[nt.addr] = {o_result[3:0], o_result[7:4]};
                    check("w", o_w, o_result);
                end else begin
                    check("result", o_result, nt.res);
                    check("w", o_w, nt.w);
                end
                check("zero", {7'h00, o_zero}, {7'h00, nt.z});
            end
        end
    end

    initial begin
        seed = $urandom(45413);
        repeat (12) @(negedge i_clock);
        check("ready", {7'h00, o_ready}, 8'h01);
        check("reset w", o_w, nibble_xor_pkg::W_RESET);
        check("reset result", o_result, 8'h00);
        check("reset flags", {6'h00, o_done, o_zero}, 8'h00);
        i_rst_n = 1'b1;
        @(negedge i_clock);
        // Back-to-back literal xor, zero and all-ones cases
        for (int i = 0; i < 10; i++) begin
            issue(LX, 1'($urandom), 7'($urandom),
                (i == 3) ? w_m : (i == 5) ? 8'hFF : 8'($urandom), 1'b0);
        end
        issue(NOP, 1'b0, 7'h00, 8'h5A, 1'b0);
        // Swap and register xor on boundary and random addresses
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
            i_instr.valid = 1'b0;
            learn(a);
            // Xor a random byte into W so later steps see real data
            issue(LX, 1'b0, a, 8'($urandom), 1'b0);
            issue(RX, nibble_xor_pkg::DEST_F, a, 8'h00, 1'b0);
            issue(SWP, nibble_xor_pkg::DEST_F, a, 8'h00, 1'b0);
            issue(SWP, nibble_xor_pkg::DEST_W, a, 8'h00, 1'b0);
            issue(RX, nibble_xor_pkg::DEST_F, a, 8'h00, 1'b0);
            issue(RX, nibble_xor_pkg::DEST_W, a, 8'h00, 1'b0);
            issue(LX, 1'b1, a, 8'($urandom), 1'b0);
            issue(RX, nibble_xor_pkg::DEST_F, a, 8'h00, 1'b0);
            issue(SWP, nibble_xor_pkg::DEST_W, a, 8'h00, 1'b0);
        end
        i_instr.valid = 1'b0;
        repeat (4) @(negedge i_clock);
        check("pending", 8'(q.size()), 8'h00);
        report_and_stop();
    end
endmodule
